// *** hw/dpo_fifo.v ***
`timescale 1ns/1ns
`default_nettype none

module dpo_fifo #(
    parameter W = 24,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;

    // Full when pointers differ only in the wrap bit.
    assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                  (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    // Pointer update; both sides may move in one cycle.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (in_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Storage write; contents need no reset.
    always @(posedge clk) begin
        if (ce && in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule // dpo_fifo

`default_nettype wire

// *** hw/dpo_i2c_target.v ***
`timescale 1ns/1ns
`default_nettype none
`include "dpo_map.vh"

module dpo_i2c_target #(
    parameter PULL_START_CYC = `DPO_PULL_START_CYC,
    parameter PULL_SETTLE_CYC = `DPO_PULL_SETTLE_CYC,
    parameter FIFO_DEPTH = `DPO_FIFO_DEPTH
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire scl_in,
    input wire sda_in,
    output reg scl_out,
    output reg scl_oe_n,
    output reg sda_out,
    output reg sda_oe_n,
    input wire [6:0] own_address,
    input wire oe_sw_ctrl,
    input wire [3:0] range_factory,
    output reg [25:0] pull_value_word,
    output reg pull_start,
    output reg pull_settling,
    output reg output_enable_sw,
    output reg [3:0] pull_range_code,
    output reg [18:0] pull_range_centi_ppm
);
    localparam [8:0] ST_IDLE = 9'h001;
    localparam [8:0] ST_ADDR = 9'h002;
    localparam [8:0] ST_AACK = 9'h004;
    localparam [8:0] ST_WRX = 9'h008;
    localparam [8:0] ST_WACK = 9'h010;
    localparam [8:0] ST_WSTALL = 9'h020;
    localparam [8:0] ST_TX = 9'h040;
    localparam [8:0] ST_TACK = 9'h080;
    localparam [8:0] ST_TDONE = 9'h100;
    localparam [15:0] START_LAST = PULL_START_CYC[15:0] - 16'h0001;
    localparam [15:0] SETTLE_LAST = PULL_SETTLE_CYC[15:0] - 16'h0001;

    // Register read view: unmapped locations and spare bits read zero.
    function [15:0] reg_read;
        input [7:0] a;
        input [15:0] lo;
        input [9:0] hi;
        input oe;
        input [3:0] rng;
        begin
            case (a)
                `DPO_REG_PULL_LO: reg_read = lo;
                `DPO_REG_PULL_HI: reg_read = {5'h00, oe, hi};
                `DPO_REG_RANGE: reg_read = {12'h000, rng};
                default: reg_read = 16'h0000;
            endcase
        end
    endfunction

    // Pull range in hundredths of a ppm, ascending with the code.
    function [18:0] range_ppm;
        input [3:0] code;
        begin
            case (code)
                4'h0: range_ppm = 19'h00271;
                4'h1: range_ppm = 19'h003E8;
                4'h2: range_ppm = 19'h004E2;
                4'h3: range_ppm = 19'h009C4;
                4'h4: range_ppm = 19'h01388;
                4'h5: range_ppm = 19'h01F40;
                4'h6: range_ppm = 19'h02710;
                4'h7: range_ppm = 19'h030D4;
                4'h8: range_ppm = 19'h03A98;
                4'h9: range_ppm = 19'h04E20;
                4'hA: range_ppm = 19'h09C40;
                4'hB: range_ppm = 19'h0EA60;
                4'hC: range_ppm = 19'h13880;
                4'hD: range_ppm = 19'h1D4C0;
                4'hE: range_ppm = 19'h27100;
                default: range_ppm = 19'h4E200;
            endcase
        end
    endfunction

    reg scl_s1, scl_s2, scl_h0, scl_h1, scl_f, scl_d;
    reg sda_s1, sda_s2, sda_h0, sda_h1, sda_f, sda_d;
    reg [8:0] state;
    reg [7:0] sreg;
    reg [3:0] bitcnt;
    reg rw;
    reg have_ptr;
    reg hi_done;
    reg [7:0] hi_byte;
    reg [7:0] ptr;
    reg [7:0] tx_sh;
    reg [15:0] tx_word;
    reg tx_lo;
    reg mack;
    reg [15:0] stage_lo;
    reg [9:0] stage_hi;
    reg strap_done;
    reg pend;
    reg [15:0] dcnt;
    reg [15:0] scnt;
    wire scl_rise, scl_fall, bus_start, bus_stop;
    wire [15:0] rd_word, rd_next;
    wire byte_end, push, fifo_in_ready, fifo_out_valid, pop;
    wire [23:0] fifo_out_data;
    wire [23:0] push_data;

    // Line sampling: two-flop synchroniser, then a three-sample filter.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_s1, scl_s2, scl_h0, scl_h1, scl_f, scl_d} <= 6'h3F;
            {sda_s1, sda_s2, sda_h0, sda_h1, sda_f, sda_d} <= 6'h3F;
        end else if (ce) begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_h0 <= scl_s2;
            scl_h1 <= scl_h0;
            if (scl_s2 == scl_h0 && scl_h0 == scl_h1) begin
                scl_f <= scl_s2;
            end
            scl_d <= scl_f;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_h0 <= sda_s2;
            sda_h1 <= sda_h0;
            if (sda_s2 == sda_h0 && sda_h0 == sda_h1) begin
                sda_f <= sda_s2;
            end
            sda_d <= sda_f;
        end
    end

    // Bus events from the filtered lines; start also covers a restart.
    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
    assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;

    // Read data for the current and the following register.
    assign rd_word = reg_read(ptr, stage_lo, stage_hi, output_enable_sw,
        pull_range_code);
    assign rd_next = reg_read(ptr + 8'h01, stage_lo, stage_hi,
        output_enable_sw, pull_range_code);

    // A complete register word is queued as pointer, high, low.
    assign byte_end = (state == ST_WRX) && scl_fall && (bitcnt == 4'h8);
    assign push = ce && !bus_start && !bus_stop &&
        ((byte_end && have_ptr && hi_done) ||
        (state == ST_WSTALL));
    assign push_data = {ptr, hi_byte, sreg};

    // Write queue between the serial side and the register file.
    dpo_fifo #(
        .W(`DPO_FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(~pend),
        .out_data(fifo_out_data)
    );
    assign pop = ce && fifo_out_valid && !pend;

    // Serial protocol engine; target only, pins driven low or released.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            sreg <= 8'h00;
            bitcnt <= 4'h0;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            hi_done <= 1'b0;
            hi_byte <= 8'h00;
            ptr <= `DPO_PTR_RESET;
            tx_sh <= 8'h00;
            tx_word <= 16'h0000;
            tx_lo <= 1'b0;
            mack <= 1'b1;
            scl_out <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (ce) begin
            if (bus_start) begin
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                have_ptr <= 1'b0;
                hi_done <= 1'b0;
                sda_oe_n <= 1'b1;
                scl_oe_n <= 1'b1;
            end else if (bus_stop) begin
                state <= ST_IDLE;
                sda_oe_n <= 1'b1;
                scl_oe_n <= 1'b1;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    ST_ADDR, ST_WRX: begin
                        if (scl_rise) begin
                            sreg <= {sreg[6:0], sda_f};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (sreg[7:1] == own_address) begin
                                    rw <= sreg[0];
                                    sda_oe_n <= 1'b0;
                                    state <= ST_AACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (!have_ptr) begin
                                ptr <= sreg;
                                have_ptr <= 1'b1;
                                sda_oe_n <= 1'b0;
                                state <= ST_WACK;
                            end else if (!hi_done) begin
                                hi_byte <= sreg;
                                hi_done <= 1'b1;
                                sda_oe_n <= 1'b0;
                                state <= ST_WACK;
                            end else if (fifo_in_ready) begin
                                ptr <= ptr + 8'h01;
                                hi_done <= 1'b0;
                                sda_oe_n <= 1'b0;
                                state <= ST_WACK;
                            end else begin
                                // Ack is pulled while the clock is held low.
                                sda_oe_n <= 1'b0;
                                scl_oe_n <= 1'b0;
                                state <= ST_WSTALL;
                            end
                        end
                    end
                    ST_WSTALL: begin
                        if (fifo_in_ready) begin
                            ptr <= ptr + 8'h01;
                            hi_done <= 1'b0;
                            sda_oe_n <= 1'b0;
                            scl_oe_n <= 1'b1;
                            state <= ST_WACK;
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state <= ST_WRX;
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                tx_word <= rd_word;
                                tx_sh <= rd_word[15:8];
                                sda_oe_n <= rd_word[15];
                                tx_lo <= 1'b0;
                                bitcnt <= 4'h1;
                                state <= ST_TX;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= ST_WRX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                state <= ST_TACK;
                            end else begin
                                sda_oe_n <= tx_sh[6];
                                tx_sh <= {tx_sh[6:0], 1'b0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_rise) begin
                            mack <= sda_f;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h1;
                            if (tx_lo) begin
                                ptr <= ptr + 8'h01;
                            end
                            if (!mack && tx_lo) begin
                                state <= ST_TDONE;
                            end else if (!tx_lo) begin
                                tx_sh <= tx_word[7:0];
                                sda_oe_n <= tx_word[7];
                                tx_lo <= 1'b1;
                                state <= ST_TX;
                            end else begin
                                tx_word <= rd_next;
                                tx_sh <= rd_next[15:8];
                                sda_oe_n <= rd_next[15];
                                tx_lo <= 1'b0;
                                state <= ST_TX;
                            end
                        end
                    end
                    ST_TDONE: begin
                        sda_oe_n <= 1'b1;
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe_n <= 1'b1;
                        scl_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Register file drained from the queue; high word arms the pull delay.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_lo <= 16'h0000;
            stage_hi <= 10'h000;
            output_enable_sw <= 1'b0;
            pull_range_code <= 4'h0;
            pull_range_centi_ppm <= 19'h00000;
            strap_done <= 1'b0;
            pend <= 1'b0;
            dcnt <= 16'h0000;
            scnt <= 16'h0000;
            pull_value_word <= `DPO_PULL_RESET;
            pull_start <= 1'b0;
            pull_settling <= 1'b0;
        end else if (ce) begin
            pull_start <= 1'b0;
            pull_range_centi_ppm <= range_ppm(pull_range_code);
            if (!strap_done) begin
                strap_done <= 1'b1;
                pull_range_code <= range_factory;
            end
            if (pop) begin
                case (fifo_out_data[23:16])
                    `DPO_REG_PULL_LO: begin
                        stage_lo <= fifo_out_data[15:0];
                    end
                    `DPO_REG_PULL_HI: begin
                        stage_hi <= fifo_out_data[9:0];
                        if (oe_sw_ctrl) begin
                            output_enable_sw <= fifo_out_data[`DPO_OE_BIT];
                        end
                        pend <= 1'b1;
                        dcnt <= START_LAST;
                    end
                    `DPO_REG_RANGE: begin
                        pull_range_code <= fifo_out_data[3:0];
                    end
                    default: begin
                        pend <= 1'b0;
                    end
                endcase
            end else if (pend) begin
                if (dcnt == 16'h0000) begin
                    pend <= 1'b0;
                    pull_value_word <= {stage_hi, stage_lo};
                    pull_start <= 1'b1;
                    pull_settling <= 1'b1;
                    scnt <= SETTLE_LAST;
                end else begin
                    dcnt <= dcnt - 16'h0001;
                end
            end
            if (pull_settling && !(pend && dcnt == 16'h0000)) begin
                if (scnt == 16'h0000) begin
                    pull_settling <= 1'b0;
                end else begin
                    scnt <= scnt - 16'h0001;
                end
            end
        end
    end
endmodule // dpo_i2c_target

`default_nettype wire

// *** hw/dpo_map.vh ***
`ifndef DPO_MAP_VH
`define DPO_MAP_VH

// Register locations reached through the two-wire target port.
`define DPO_REG_PULL_LO 8'h00
`define DPO_REG_PULL_HI 8'h01
`define DPO_REG_RANGE 8'h02

// Field layout of the pull word and range registers.
`define DPO_OE_BIT 10
`define DPO_PULL_HI_W 10
`define DPO_PULL_W 26
`define DPO_RANGE_W 4

// Reset values.
`define DPO_PTR_RESET 8'h00
`define DPO_PULL_RESET 26'h0000000

// Timing in nanoseconds and the derived cycle counts at 20 MHz.
`define DPO_CLK_PERIOD_NS 50
`define DPO_PULL_START_DELAY_NS 140000
`define DPO_PULL_SETTLE_NS 20000
`define DPO_PULL_START_CYC (`DPO_PULL_START_DELAY_NS / `DPO_CLK_PERIOD_NS)
`define DPO_PULL_SETTLE_CYC (`DPO_PULL_SETTLE_NS / `DPO_CLK_PERIOD_NS)

// Write queue shape: pointer, high byte, low byte.
`define DPO_FIFO_W 24
`define DPO_FIFO_DEPTH 32

`endif

// *** verif/dpo_ctl_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Bus controller: pulls the lines low or lets them float high.
module dpo_ctl_model (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low = 1'b0,
    output logic sda_low = 1'b0,
    output logic hung = 1'b0
);
    // Waits a number of clock edges.
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask

    // START, or repeated START from a low clock; leaves SCL low.
    task automatic start;
        gap(12);
        sda_low <= 1'b0;
        gap(6);
        scl_low <= 1'b0;
        gap(8);
        sda_low <= 1'b1;
        gap(8);
        scl_low <= 1'b1;
    endtask

    // STOP: SDA rises while SCL is high.
    task automatic stop;
        gap(4);
        sda_low <= 1'b1;
        gap(10);
        scl_low <= 1'b0;
        gap(8);
        sda_low <= 1'b0;
        gap(8);
    endtask

    // One bit: data set in the low phase, sampled late in the high.
    task automatic bit_io(input logic b, output logic r);
        int n;
        gap(4);
        sda_low <= !b;
        gap(10);
        scl_low <= 1'b0;
        n = 0;
        @(posedge clk);
        while (!scl && n < 20000) begin
            n++;
            @(posedge clk);
        end
        hung <= hung | (n >= 20000);
        gap(6);
        r = sda;
        scl_low <= 1'b1;
    endtask

    // Sends a byte, most significant bit first; true on ack.
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Receives a byte, then answers with ack or not-acknowledge.
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule // dpo_ctl_model
`default_nettype wire

// *** verif/dpo_i2c_target_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dpo_tb_defs.svh"

// Watches the target pins and the pull outputs over time.
module dpo_i2c_mon #(
    parameter int PULL_START_CYC = 2800,
    parameter int PULL_SETTLE_CYC = 400,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [6:0] own_address,
    input wire logic oe_sw_ctrl,
    input wire logic [3:0] range_factory,
    input wire logic [25:0] pull_value_word,
    input wire logic pull_start,
    input wire logic pull_settling,
    input wire logic output_enable_sw,
    input wire logic [3:0] pull_range_code,
    input wire logic [18:0] pull_range_centi_ppm
);
    int since_start;
    logic [1:0] up;

    // Counts cycles since the last pull start and edges since reset, holding at three.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_start <= 0;
            up <= 2'h0;
        end else begin
            since_start <= pull_start ? 0 : since_start + 1;
            up <= (up == 2'h3) ? up : up + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // The settle window opens with the start pulse or one cycle later.
    sequence s_settle_open;
        ##[0:1] pull_settling;
    endsequence

    a_pull_one_cycle: assert property (pull_start |=> !pull_start)
        else $error("pull start pulse too long");
    a_settle_opens: assert property (pull_start |-> s_settle_open)
        else $error("settle window did not open");
    a_settle_bound: assert property (
        pull_settling && !pull_start |-> since_start <= PULL_SETTLE_CYC)
        else $error("settle window too long");
    a_settle_length: assert property (
        $fell(pull_settling) |-> since_start >= PULL_SETTLE_CYC - 1)
        else $error("settle window too short");
    a_word_on_start: assert property (
        !$stable(pull_value_word) |-> pull_start || $past(pull_start))
        else $error("pull value moved without a start");
    a_range_decode: assert property (
        up == 2'h3 |-> pull_range_centi_ppm == dpo_ppm($past(pull_range_code)))
        else $error("range decode wrong");
    a_open_drain: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_stretch_low: assert property ($fell(scl_oe_n) |-> !scl_in)
        else $error("clock held while high");
    a_sda_moves_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("data moved while clock high");
    a_oe_sw_only: assert property (
        !$stable(output_enable_sw) |-> oe_sw_ctrl)
        else $error("output enable moved under pin control");
endmodule // dpo_i2c_mon

bind dpo_i2c_target dpo_i2c_mon #(.PULL_START_CYC(PULL_START_CYC),
    .PULL_SETTLE_CYC(PULL_SETTLE_CYC), .FIFO_DEPTH(FIFO_DEPTH)) mon (
    .clk(clk), .arst_n(arst_n), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .own_address(own_address), .oe_sw_ctrl(oe_sw_ctrl),
    .range_factory(range_factory), .pull_value_word(pull_value_word),
    .pull_start(pull_start), .pull_settling(pull_settling),
    .output_enable_sw(output_enable_sw), .pull_range_code(pull_range_code),
    .pull_range_centi_ppm(pull_range_centi_ppm));
`default_nettype wire

// *** verif/dpo_tb_defs.svh ***
`ifndef DPO_TB_DEFS_SVH
`define DPO_TB_DEFS_SVH
// Pull range in hundredths of a ppm for each select code.
function automatic logic [18:0] dpo_ppm(input logic [3:0] c);
    logic [18:0] t [16];
    t = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500, 15000, 20000,
        40000, 60000, 80000, 120000, 160000, 320000};
    return t[c];
endfunction
`endif

// *** verif/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dpo_tb_defs.svh"

`define CHK(N, E, G) begin check_count++; if ((G) !== (E)) begin \
    mismatches++; $display("wrong value %s expected %0h seen %0h", N, E, G); \
    end end

module testbench;
    localparam int PS = 16000;
    logic clk = 1'b0;
    logic arst_n, ce, oe_sw_ctrl, scl, sda, scl_low, sda_low, hung, k;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, pull_start, pull_settling;
    logic output_enable_sw;
    logic [6:0] own_address;
    logic [3:0] range_factory, pull_range_code, rf;
    logic [25:0] pull_value_word;
    logic [18:0] pull_range_centi_ppm;
    logic [15:0] lo, hi, v;
    logic [15:0] q[$], r[$];
    int seed, mismatches, check_count, pulses, stretch, s0, p0;

    // Open-drain lines: pulled up, low when either party pulls down.
    assign scl = !scl_low && (scl_oe_n || scl_out);
    assign sda = !sda_low && (sda_oe_n || sda_out);

    always #25 clk = ~clk;

    // Counts pull start pulses and cycles of clock stretching.
    always @(posedge clk) begin
        pulses <= pulses + int'(pull_start === 1'b1);
        stretch <= stretch + int'(scl_oe_n === 1'b0);
    end

    dpo_i2c_target #(.PULL_START_CYC(PS), .PULL_SETTLE_CYC(10),
        .FIFO_DEPTH(32)) uut (.clk(clk), .arst_n(arst_n), .ce(ce),
        .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .own_address(own_address),
        .oe_sw_ctrl(oe_sw_ctrl), .range_factory(range_factory),
        .pull_value_word(pull_value_word), .pull_start(pull_start),
        .pull_settling(pull_settling), .output_enable_sw(output_enable_sw),
        .pull_range_code(pull_range_code),
        .pull_range_centi_ppm(pull_range_centi_ppm));

    dpo_ctl_model ctl (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low), .hung(hung));

    // Writes words from register a onward and checks every ack.
    task automatic wreg(input logic [7:0] a, input logic [15:0] w[$]);
        logic ak, all;
        ctl.start();
        ctl.wr({own_address, 1'b0}, ak);
        all = ak;
        ctl.wr(a, ak);
        all &= ak;
        foreach (w[i]) begin
            ctl.wr(w[i][15:8], ak);
            all &= ak;
            ctl.wr(w[i][7:0], ak);
            all &= ak;
        end
        ctl.stop();
        `CHK("write acks", 1'b1, all)
    endtask

    // Reads n words, optionally setting the pointer first.
    task automatic rreg(input logic set, input logic [7:0] a, input int n,
        output logic [15:0] o[$]);
        logic ak;
        logic [15:0] w;
        o = {};
        ctl.start();
        if (set) begin
            ctl.wr({own_address, 1'b0}, ak);
            ctl.wr(a, ak);
            ctl.start();
        end
        ctl.wr({own_address, 1'b1}, ak);
        for (int i = 0; i < n; i++) begin
            ctl.rd(1'b1, w[15:8]);
            ctl.rd(i == n - 1, w[7:0]);
            o.push_back(w);
        end
        ctl.stop();
    endtask

    // Waits for the pull start, then checks its timing and the value.
    task automatic wait_pull(input logic [25:0] w, input int min_n);
        int n;
        n = 0;
        while (pull_start !== 1'b1 && n < PS + 50) begin
            @(negedge clk);
            n++;
        end
        `CHK("pull delay", 1'b1, n >= min_n && n <= PS)
        repeat (2) @(negedge clk);
        `CHK("pull word", w, pull_value_word)
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence: reset, then the scenarios in turn.
    initial begin
        seed = 64556;
        arst_n = 1'b0;
        ce = 1'b1;
        oe_sw_ctrl = 1'b0;
        own_address = 7'($random(seed));
        rf = 4'($random(seed));
        range_factory = rf;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (12) @(negedge clk);
        `CHK("range reset", rf, pull_range_code)
        `CHK("pull reset", 26'h0000000, pull_value_word)
        `CHK("oe reset", 1'b0, output_enable_sw)
        rreg(1'b0, 8'h00, 3, r);
        `CHK("read at zero", 16'h0000, r[0])
        `CHK("nack goes on", {12'h000, rf}, r[2])
        ctl.start();
        ctl.wr({own_address ^ 7'h01, 1'b0}, k);
        ctl.stop();
        `CHK("foreign ack", 1'b0, k)
        for (int c = 0; c < 16; c++) begin
            v = 16'($random(seed));
            v[3:0] = c[3:0];
            wreg(8'h02, {v});
            repeat (8) @(negedge clk);
            `CHK("range code", c[3:0], pull_range_code)
            `CHK("range ppm", dpo_ppm(c[3:0]), pull_range_centi_ppm)
            rreg(1'b1, 8'h02, 1, r);
            `CHK("range read", {12'h000, c[3:0]}, r[0])
        end
        oe_sw_ctrl <= 1'b1;
        lo = 16'($random(seed));
        hi = 16'($random(seed)) | 16'h0400;
        wreg(8'hFF, {16'h1234, lo});
        repeat (40) @(negedge clk);
        `CHK("low word idle", 0, pulses)
        wreg(8'h01, {hi});
        wait_pull({hi[9:0], lo}, PS - 120);
        `CHK("oe set", 1'b1, output_enable_sw)
        rreg(1'b1, 8'h00, 2, r);
        `CHK("low read", lo, r[0])
        `CHK("high read", {6'h01, hi[9:0]}, r[1])
        oe_sw_ctrl <= 1'b0;
        q = {16'h0000};
        for (int i = 0; i < 34; i++)
            q.push_back(16'($random(seed)));
        s0 = stretch;
        p0 = pulses;
        wreg(8'h01, q);
        `CHK("stretched", 1'b1, stretch > s0)
        `CHK("queued pull", 1'b1, pulses == p0 + 1)
        `CHK("queued pull word", {10'h000, lo}, pull_value_word)
        `CHK("oe kept", 1'b1, output_enable_sw)
        repeat (20) @(negedge clk);
        rreg(1'b1, 8'h02, 1, r);
        `CHK("queued word", {12'h000, q[1][3:0]}, r[0])
        `CHK("bus hang", 1'b0, hung)
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
